// ===== verilog/gtc_pkg.sv
// Shared constants for the general timer/counter
package gtc_pkg;
	localparam int CNT_W = 32;
	localparam int NUM_CAP = 4;
	localparam int NUM_MATCH = 4;
	localparam int SYNC_STAGES = 3;
	// Match output actions
	localparam logic [1:0] ACT_NONE = 2'h0;
	localparam logic [1:0] ACT_LOW = 2'h1;
	localparam logic [1:0] ACT_HIGH = 2'h2;
	localparam logic [1:0] ACT_TOGGLE = 2'h3;
	// Count source edge select bit positions
	localparam int EDGE_RISE_BIT = 0;
	localparam int EDGE_FALL_BIT = 1;
	// Reset values
	localparam logic [CNT_W-1:0] CNT_RESET = 32'h0000_0000;
	localparam logic [NUM_MATCH-1:0] MATCH_OUT_RESET = 4'h0;
endpackage

// ===== verilog/gtc_pin_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module gtc_pin_sync #(
	parameter int WIDTH = 4
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] pin_raw,
	output logic [WIDTH-1:0] pin_level
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] level;
	} gtc_sync_s;

	gtc_sync_s st;
	gtc_sync_s next_st;

	initial
	begin
		if (WIDTH < 1)
			$error("gtc_pin_sync: WIDTH must be at least 1");
	end

	// Level only moves when stages two and three agree; s1 feeds s2 alone
	always_comb
	begin
		next_st = st;
		next_st.s1 = pin_raw;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		for (int i = 0; i < WIDTH; i++)
		begin
			if (st.s2[i] == st.s3[i])
				next_st.level[i] = st.s3[i];
		end
	end

	// Registers the whole state copy
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			st <= '0;
		else
			st <= next_st;
	end

	assign pin_level = st.level;
endmodule // gtc_pin_sync
`default_nettype wire

// ===== verilog/gtc_timer.sv
// General timer/counter with prescaler, capture and match channels
`timescale 1ns/1ps
`default_nettype none
module gtc_timer #(
	parameter int NUM_PINS = gtc_pkg::NUM_CAP,
	parameter int SEL_W = (NUM_PINS > 1) ? $clog2(NUM_PINS) : 1
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic enable,
	input wire logic counter_reset,
	input wire logic event_mode,
	input wire logic [SEL_W-1:0] count_pin_sel,
	input wire logic [1:0] count_edge_sel,
	input wire logic [gtc_pkg::CNT_W-1:0] prescale_limit,
	input wire logic [gtc_pkg::NUM_MATCH-1:0][gtc_pkg::CNT_W-1:0] match_value,
	input wire logic [gtc_pkg::NUM_MATCH-1:0] match_int_en,
	input wire logic [gtc_pkg::NUM_MATCH-1:0] match_stop_en,
	input wire logic [gtc_pkg::NUM_MATCH-1:0] match_reset_en,
	input wire logic [gtc_pkg::NUM_MATCH-1:0][1:0] match_action,
	input wire logic [gtc_pkg::NUM_MATCH-1:0][NUM_PINS-1:0] match_pin_mask,
	input wire logic [gtc_pkg::NUM_MATCH-1:0] match_flag_clear,
	input wire logic [NUM_PINS-1:0] capture_input_pin,
	input wire logic [gtc_pkg::NUM_CAP-1:0][NUM_PINS-1:0] capture_pin_mask,
	input wire logic [gtc_pkg::NUM_CAP-1:0] capture_and_mode,
	input wire logic [gtc_pkg::NUM_CAP-1:0] capture_rise_en,
	input wire logic [gtc_pkg::NUM_CAP-1:0] capture_fall_en,
	input wire logic [gtc_pkg::NUM_CAP-1:0] capture_int_en,
	input wire logic [gtc_pkg::NUM_CAP-1:0] capture_flag_clear,
	output logic [gtc_pkg::CNT_W-1:0] count,
	output logic [gtc_pkg::CNT_W-1:0] prescale_count,
	output logic [gtc_pkg::NUM_CAP-1:0][gtc_pkg::CNT_W-1:0] capture_value,
	output logic [gtc_pkg::NUM_CAP-1:0] capture_flag,
	output logic [gtc_pkg::NUM_MATCH-1:0] match_flag,
	output logic [gtc_pkg::NUM_MATCH-1:0] match_out,
	output logic [NUM_PINS-1:0] match_pin,
	output logic stopped,
	output logic irq
);
	localparam int NC = gtc_pkg::NUM_CAP;
	localparam int NM = gtc_pkg::NUM_MATCH;
	localparam int W = gtc_pkg::CNT_W;

	typedef struct packed {
		logic [W-1:0] tc;
		logic [W-1:0] pc;
		logic [NC-1:0][W-1:0] cap;
		logic [NC-1:0] cap_flag;
		logic [NM-1:0] m_flag;
		logic [NM-1:0] m_out;
		logic [NUM_PINS-1:0] m_pin;
		logic [NC-1:0] cap_prev;
		logic cnt_prev;
		logic stopped;
		logic irq;
	} gtc_state_s;

	gtc_state_s st;
	gtc_state_s next_st;
	logic [NUM_PINS-1:0] pin_level;
	logic src_evt;
	logic run;
	logic tick;
	logic [NM-1:0] hit;
	logic [NC-1:0] cap_trig;

	initial
	begin
		if (NUM_PINS < 1 || (1 << SEL_W) < NUM_PINS)
			$error("gtc_timer: NUM_PINS or SEL_W out of range");
	end

	// Pins cross into this domain before any edge is looked at
	gtc_pin_sync #(
		.WIDTH(NUM_PINS)
	) u_sync (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.pin_raw(capture_input_pin),
		.pin_level(pin_level)
	);

	// Next-state logic for counting, capture, match and flags
	always_comb
	begin
		logic cnt_lvl;
		logic c_lvl;
		logic c_rise;
		logic c_fall;
		cnt_lvl = 1'b0;
		c_lvl = 1'b0;
		c_rise = 1'b0;
		c_fall = 1'b0;
		next_st = st;
		// One selected pin feeds the counter; the rest stay free
		cnt_lvl = pin_level[count_pin_sel];
		next_st.cnt_prev = cnt_lvl;
		// Edge on the synchronised level; input rate must stay below
		// a quarter clock or edges merge in the synchroniser
		src_evt = event_mode ?
			((count_edge_sel[gtc_pkg::EDGE_RISE_BIT] & cnt_lvl & ~st.cnt_prev) |
			(count_edge_sel[gtc_pkg::EDGE_FALL_BIT] & ~cnt_lvl & st.cnt_prev))
			: 1'b1;
		run = enable & ~st.stopped;
		tick = run & src_evt & (st.pc == prescale_limit);
		// Prescaler counts source events and wraps at its limit
		if (run & src_evt)
			next_st.pc = tick ? '0 : st.pc + 1'b1;
		for (int i = 0; i < NM; i++)
			hit[i] = tick & (st.tc == match_value[i]);
		if (tick)
			next_st.tc = st.tc + 1'b1;
		// Reset wins over stop so a reset-and-stop parks at zero
		if (|(hit & match_stop_en))
		begin
			next_st.tc = st.tc;
			next_st.stopped = 1'b1;
		end
		if (|(hit & match_reset_en))
			next_st.tc = '0;
		// Match flags and output actions; set beats clear
		for (int i = 0; i < NM; i++)
		begin
			if (match_flag_clear[i])
				next_st.m_flag[i] = 1'b0;
			if (hit[i] & match_int_en[i])
				next_st.m_flag[i] = 1'b1;
			if (hit[i])
			begin
				unique case (match_action[i])
					gtc_pkg::ACT_NONE: next_st.m_out[i] = st.m_out[i];
					gtc_pkg::ACT_LOW: next_st.m_out[i] = 1'b0;
					gtc_pkg::ACT_HIGH: next_st.m_out[i] = 1'b1;
					gtc_pkg::ACT_TOGGLE: next_st.m_out[i] = ~st.m_out[i];
				endcase
			end
		end
		// Capture channels combine their pins by OR or AND
		for (int c = 0; c < NC; c++)
		begin
			if (capture_and_mode[c])
				c_lvl = (|capture_pin_mask[c]) &
					(&(pin_level | ~capture_pin_mask[c]));
			else
				c_lvl = |(pin_level & capture_pin_mask[c]);
			c_rise = c_lvl & ~st.cap_prev[c];
			c_fall = ~c_lvl & st.cap_prev[c];
			next_st.cap_prev[c] = c_lvl;
			// Independent of the count source pin, so free pins still work
			cap_trig[c] = (capture_rise_en[c] & c_rise) |
				(capture_fall_en[c] & c_fall);
			if (cap_trig[c])
				next_st.cap[c] = st.tc;
			if (capture_flag_clear[c])
				next_st.cap_flag[c] = 1'b0;
			if (cap_trig[c] & capture_int_en[c])
				next_st.cap_flag[c] = 1'b1;
		end
		// Software reset of the count overrides the count, prescaler and stop state set above
		if (counter_reset)
		begin
			next_st.tc = gtc_pkg::CNT_RESET;
			next_st.pc = gtc_pkg::CNT_RESET;
			next_st.stopped = 1'b0;
		end
		// Broadcast: each pin ORs the match outputs routed to it
		for (int p = 0; p < NUM_PINS; p++)
		begin
			next_st.m_pin[p] = 1'b0;
			for (int i = 0; i < NM; i++)
				next_st.m_pin[p] = next_st.m_pin[p] |
					(next_st.m_out[i] & match_pin_mask[i][p]);
		end
		next_st.irq = (|next_st.m_flag) | (|next_st.cap_flag);
	end

	// Registers the whole state copy
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			st <= '0;
			st.m_out <= gtc_pkg::MATCH_OUT_RESET;
		end
		else
			st <= next_st;
	end

	assign count = st.tc;
	assign prescale_count = st.pc;
	assign capture_value = st.cap;
	assign capture_flag = st.cap_flag;
	assign match_flag = st.m_flag;
	assign match_out = st.m_out;
	assign match_pin = st.m_pin;
	assign stopped = st.stopped;
	assign irq = st.irq;

	// Checks on the counting, capture, match and interrupt paths
	property p_tc_step;
		@(posedge ref_clk) disable iff (sys_rst)
		tick && hit == '0 && !counter_reset |=> count == $past(count) + 1'b1;
	endproperty
	a_tc_step: assert property (p_tc_step) else $error("count did not step");

	property p_pc_wrap;
		@(posedge ref_clk) disable iff (sys_rst)
		tick && !counter_reset |=> prescale_count == '0;
	endproperty
	a_pc_wrap: assert property (p_pc_wrap) else $error("prescaler no wrap");

	property p_evt_hold;
		@(posedge ref_clk) disable iff (sys_rst)
		event_mode && !src_evt && !counter_reset |=>
			$stable(prescale_count) && $stable(count);
	endproperty
	a_evt_hold: assert property (p_evt_hold) else $error("count moved idle");

	property p_cap_load;
		@(posedge ref_clk) disable iff (sys_rst)
		cap_trig[0] |=> capture_value[0] == $past(count);
	endproperty
	a_cap_load: assert property (p_cap_load) else $error("capture wrong");

	property p_cap_mask;
		@(posedge ref_clk) disable iff (sys_rst)
		!capture_flag[0] && !(cap_trig[0] && capture_int_en[0]) |=>
			!capture_flag[0];
	endproperty
	a_cap_mask: assert property (p_cap_mask) else $error("capture flag spurious");

	property p_match_flag;
		@(posedge ref_clk) disable iff (sys_rst)
		hit[0] && match_int_en[0] |=> match_flag[0] && irq;
	endproperty
	a_match_flag: assert property (p_match_flag) else $error("match flag lost");

	property p_stop;
		@(posedge ref_clk) disable iff (sys_rst)
		|(hit & match_stop_en) && !(|(hit & match_reset_en)) &&
		!counter_reset |=> stopped && count == $past(count);
	endproperty
	a_stop: assert property (p_stop) else $error("stop on match failed");

	property p_reset;
		@(posedge ref_clk) disable iff (sys_rst)
		hit[0] && match_reset_en[0] |=> count == '0;
	endproperty
	a_reset: assert property (p_reset) else $error("reset on match failed");

	property p_toggle;
		@(posedge ref_clk) disable iff (sys_rst)
		hit[3] && match_action[3] == gtc_pkg::ACT_TOGGLE |=>
			match_out[3] != $past(match_out[3]);
	endproperty
	a_toggle: assert property (p_toggle) else $error("toggle failed");

	property p_irq;
		@(posedge ref_clk) disable iff (sys_rst)
		irq == ((|match_flag) | (|capture_flag));
	endproperty
	a_irq: assert property (p_irq) else $error("irq not merged");

	c_event_tick: cover property (@(posedge ref_clk) disable iff (sys_rst)
		event_mode && tick);
	c_capture: cover property (@(posedge ref_clk) disable iff (sys_rst)
		cap_trig[0] && capture_int_en[0]);
	c_stop: cover property (@(posedge ref_clk) disable iff (sys_rst)
		|(hit & match_stop_en));
	c_reset: cover property (@(posedge ref_clk) disable iff (sys_rst)
		|(hit & match_reset_en));
endmodule // gtc_timer
`default_nettype wire

// ===== test/gtc_pin_model.sv
// Far-side model driving the external capture pins
`timescale 1ns/1ps
`default_nettype none
module gtc_pin_model (
	input wire logic ref_clk,
	output logic [3:0] pins
);
	// Idle pins rest low, as with a pull-down
	initial pins = 4'h0;
	// Three cycles high, four low between pulses: slower than clk/4, levels over 2 cycles
	task automatic pulse(input logic [3:0] m, input int n);
		repeat (n)
		begin
			@(posedge ref_clk) pins <= m;
			repeat (3) @(posedge ref_clk);
			pins <= 4'h0;
			repeat (3) @(posedge ref_clk);
		end
	endtask
endmodule // gtc_pin_model
`default_nettype wire

// ===== test/tb_top.sv
// Self-checking bench for the general timer/counter
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	typedef struct {int k; logic [31:0] v;} gtc_note_s;
	logic ref_clk, sys_rst, enable, counter_reset, event_mode;
	logic [1:0] count_pin_sel, count_edge_sel;
	logic [31:0] prescale_limit;
	logic [3:0][31:0] match_value;
	logic [3:0] match_int_en, match_stop_en, match_reset_en, match_flag_clear;
	logic [3:0][1:0] match_action;
	logic [3:0][3:0] match_pin_mask, capture_pin_mask;
	logic [3:0] capture_input_pin, capture_and_mode, capture_rise_en;
	logic [3:0] capture_fall_en, capture_int_en, capture_flag_clear;
	logic [31:0] count, prescale_count;
	logic [3:0][31:0] capture_value;
	logic [3:0] capture_flag, match_flag, match_out, match_pin;
	logic stopped, irq;
	int mismatches = 0;
	int samples_checked = 0;
	int seed = 32'h2fed;
	int n;
	gtc_note_s q[$];
	gtc_note_s e;
	event look;
	gtc_timer i_gtc_timer (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.enable(enable), .counter_reset(counter_reset),
		.event_mode(event_mode), .count_pin_sel(count_pin_sel),
		.count_edge_sel(count_edge_sel), .prescale_limit(prescale_limit),
		.match_value(match_value), .match_int_en(match_int_en),
		.match_stop_en(match_stop_en), .match_reset_en(match_reset_en),
		.match_action(match_action), .match_pin_mask(match_pin_mask),
		.match_flag_clear(match_flag_clear),
		.capture_input_pin(capture_input_pin),
		.capture_pin_mask(capture_pin_mask),
		.capture_and_mode(capture_and_mode),
		.capture_rise_en(capture_rise_en), .capture_fall_en(capture_fall_en),
		.capture_int_en(capture_int_en),
		.capture_flag_clear(capture_flag_clear), .count(count),
		.prescale_count(prescale_count), .capture_value(capture_value),
		.capture_flag(capture_flag), .match_flag(match_flag),
		.match_out(match_out), .match_pin(match_pin), .stopped(stopped),
		.irq(irq));
	gtc_pin_model i_gtc_pin_model (.ref_clk(ref_clk), .pins(capture_input_pin));
	// Clock
	initial
	begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end
	// Output picked by a note's key; narrow ones are zero-extended
	function automatic logic [31:0] obs(input int k);
		case (k)
			0: return count;
			1: return {28'h0, match_out};
			2: return {28'h0, match_pin};
			3: return capture_value[0];
			4: return {28'h0, capture_flag};
			5: return {31'h0, irq};
			6: return {31'h0, stopped};
			8: return {28'h0, match_flag};
			default: return prescale_count;
		endcase
	endfunction
	// Driver side notes an expectation and wakes the watcher
	task automatic expect_v(input int k, input logic [31:0] v);
		q.push_back('{k, v});
		-> look;
	endtask
	// Bounded wait until any masked bit of an output is high
	task automatic wait_obs(input int k, input logic [31:0] m);
		// Step off the edge first so a value about to change is not seen
		#1;
		repeat (400)
			if ((obs(k) & m) == 32'h0)
			begin
				@(posedge ref_clk);
				#1;
			end
	endtask
	// Watcher: takes every queued note, oldest first, whenever a result is presented
	initial
		forever
		begin
			@(look);
			while (q.size() > 0)
			begin
				e = q.pop_front();
				samples_checked++;
				if (obs(e.k) !== e.v)
				begin
					mismatches++;
					$display("BAD t=%0t exp=%h got=%h", $time, e.v, obs(e.k));
				end
			end
		end
	task automatic close_out();
		-> look;
		#1;
		$display("checked %0d mismatched %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Watchdog sized well above the expected run of about a hundred cycles
	initial
	begin
		#20000;
		mismatches++;
		close_out();
	end
	// Main sequence
	initial
	begin
		{sys_rst, enable, counter_reset, event_mode} = 4'h8;
		{count_pin_sel, count_edge_sel} = 4'h0;
		prescale_limit = 32'h0000_0001;
		match_value = {4{32'h0000_0002}};
		{match_int_en, match_stop_en, match_reset_en} = 12'hF01;
		match_flag_clear = 4'h0;
		match_action = {2'h3, 2'h2, 2'h1, 2'h0};
		match_pin_mask = {4'h1, 4'h2, 4'h0, 4'h0};
		// Channels 0 and 1 OR pin 0; channel 2 ANDs pins 0 and 1
		capture_pin_mask = {4'h0, 4'h3, 4'h1, 4'h1};
		{capture_and_mode, capture_rise_en, capture_fall_en} = 12'h470;
		{capture_int_en, capture_flag_clear} = 8'h50;
		repeat (6) @(posedge ref_clk);
		#1;
		expect_v(0, 32'h0);
		expect_v(5, 32'h0);
		sys_rst = 1'b0;
		// Timer mode, divide by two, reset at 2, every output action used
		@(posedge ref_clk) enable <= 1'b1;
		wait_obs(1, 32'h8);
		expect_v(0, 32'h0);
		expect_v(1, 32'hC);
		expect_v(2, 32'h3);
		expect_v(8, 32'hF);
		@(posedge ref_clk) match_flag_clear <= 4'hF;
		@(posedge ref_clk) match_flag_clear <= 4'h0;
		#1;
		expect_v(8, 32'h0);
		// The flag comes back only with the next match
		wait_obs(8, 32'h1);
		expect_v(1, 32'h4);
		expect_v(2, 32'h2);
		$display("test timer_reset done");
		// Stop at 5 with divide by three
		@(posedge ref_clk)
		begin
			match_reset_en <= 4'h0;
			match_stop_en <= 4'h2;
			match_value[1] <= 32'h0000_0005;
			prescale_limit <= 32'h0000_0002;
			counter_reset <= 1'b1;
		end
		@(posedge ref_clk) counter_reset <= 1'b0;
		wait_obs(6, 32'h1);
		expect_v(0, 32'h5);
		expect_v(7, 32'h0);
		repeat (4) @(posedge ref_clk);
		#1;
		expect_v(0, 32'h5);
		// Capture on a halted count; channel 1 has no interrupt enable
		// and channel 2 must stay quiet with only one of its pins high
		i_gtc_pin_model.pulse(4'h1, 1);
		wait_obs(4, 32'h1);
		expect_v(3, 32'h5);
		expect_v(4, 32'h1);
		$display("test stop_capture done");
		// Event mode on both edges of pin 2, random pulse count
		n = 2 + ($random(seed) & 3);
		@(posedge ref_clk)
		begin
			counter_reset <= 1'b1;
			match_stop_en <= 4'h0;
			match_value <= {4{32'hFFFF_FFFF}};
			event_mode <= 1'b1;
			count_pin_sel <= 2'h2;
			count_edge_sel <= 2'h3;
			prescale_limit <= 32'h0;
		end
		@(posedge ref_clk) counter_reset <= 1'b0;
		i_gtc_pin_model.pulse(4'h4, n);
		repeat (8) @(posedge ref_clk);
		#1;
		expect_v(0, 2 * n);
		// Pins 0 and 1 still capture but never count
		i_gtc_pin_model.pulse(4'h3, 1);
		#1;
		expect_v(3, 2 * n);
		expect_v(4, 32'h5);
		expect_v(0, 2 * n);
		expect_v(5, 32'h1);
		@(posedge ref_clk)
		begin
			match_flag_clear <= 4'hF;
			capture_flag_clear <= 4'hF;
		end
		@(posedge ref_clk)
		begin
			match_flag_clear <= 4'h0;
			capture_flag_clear <= 4'h0;
		end
		repeat (2) @(posedge ref_clk);
		#1;
		expect_v(5, 32'h0);
		$display("test event_count done");
		close_out();
	end
endmodule // tb_top
`default_nettype wire
